// *** rtl/panel_params.svh ***
// Constants for the mixer front-panel effects control logic
`ifndef PANEL_PARAMS_SVH
`define PANEL_PARAMS_SVH

// ----------
// Clock and timing
// ----------
`define PANEL_CLK_HZ          10000000
`define PANEL_DEBOUNCE_US     5000
`define PANEL_DEBOUNCE_CYCLES ((`PANEL_DEBOUNCE_US) * ((`PANEL_CLK_HZ) / 1000000))

// ----------
// Push switch indices in the button vector
// ----------
`define BTN_COUNT        15
`define BTN_PROC_SELECT  0
`define BTN_INSERT_FIRST 1
`define BTN_INSERT_COUNT 4
`define BTN_FX_CUE       5
`define BTN_FX_ENABLE    6
`define BTN_JOY_FIRST    7
`define BTN_ENC_FIRST    9
`define BTN_MIC          11
`define BTN_MASTER_CUE   12
`define BTN_LOOP_FIRST   13

// ----------
// Audio streaming and joy-switch position width
// ----------
`define STREAM_CHANNELS   4
`define STREAM_WIDTH      16
`define INTERNAL_WIDTH    24
`define STREAM_COUNT      2
`define SRC_CODE_COUNT    3'h6
`define JOY_POS_WIDTH     3

`endif

// *** rtl/panel_pkg.sv ***
// Types for the mixer front-panel effects control logic
package panel_pkg;

  // ----------
  // Enumerations
  // ----------
  typedef enum logic [2:0] {LOC_NONE, LOC_PGM1, LOC_PGM2, LOC_AUX, LOC_MAIN} insert_loc_t;
  typedef enum logic       {EFFECT_ECHO, EFFECT_LFO_FILTER} effect_t;
  typedef enum logic [1:0] {OWNER_NONE, OWNER_PROC1, OWNER_PROC2} owner_t;
  typedef enum logic [2:0] {SRC_PGM1_PRE, SRC_PGM1_POST, SRC_PGM2_PRE, SRC_PGM2_POST,
                            SRC_MAIN_MIX, SRC_AUX_SUM} stream_src_t;

  // ----------
  // Complete panel state
  // ----------
  typedef struct packed {
    logic                   sel;                 // 0: processor one, 1: processor two
    logic [1:0]             fx_on;
    insert_loc_t [1:0]      loc;
    logic [1:0][1:0]        joy_mode;            // [processor][joy]
    logic [1:0][1:0]        enc_mode;            // [processor][encoder]
    logic                   fx_cue;
    logic                   mic_on;
    logic                   master_cue;
    logic                   cue_pan_active;
    logic [1:0]             loop_assign;
    logic [1:0]             loop_via_fx;
    owner_t                 loop_fx_owner;
    owner_t [3:0]           point_owner;
    logic [1:0]             post_fader;
    logic [1:0]             joy_lamp;
    logic [1:0]             enc_lamp;
    logic                   mic_clip;
    logic                   usb_link;
    logic [1:0][2:0]        joy_pos;
    logic [1:0]             joy_transform_valid;
    logic [1:0]             joy_param_valid;
    logic [1:0][1:0]        enc_step;            // [encoder][parameter]
    logic [1:0]             enc_dir;
    logic [1:0]             tap;
    stream_src_t [1:0]      src;
    logic                   sample_valid;
    logic [3:0][15:0]       to_host;
    logic [3:0][23:0]       from_host;
  } panel_state_t;

endpackage : panel_pkg

// *** rtl/button_if.sv ***
// Debounced button bundle between the panel logic and its debouncer
`timescale 1ns/1ns
`default_nettype none

interface button_if #(
  parameter int N = 15
);
  logic [N-1:0] raw;
  logic [N-1:0] level;
  logic [N-1:0] press;

  modport debouncer (input raw, output level, output press);
  modport panel     (output raw, input level, input press);
endinterface : button_if

`default_nettype wire

// *** rtl/button_debounce.sv ***
// Debouncer and press detector for a group of panel push switches
`timescale 1ns/1ns
`default_nettype none

module button_debounce #(
  parameter int N      = 15,
  parameter int CYCLES = 50000
) (
  input  wire logic    clk_i,
  input  wire logic    rstn_i,
  button_if.debouncer  btn
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  typedef struct packed {
    logic [N-1:0][CW-1:0] cnt;
    logic [N-1:0]         stable;
    logic [N-1:0]         press;
  } db_state_t;

  db_state_t s_reg;
  db_state_t s_next;

  // ----------
  // Level must differ for the full interval before it is accepted
  // ----------
  always_comb begin
    s_next       = s_reg;
    s_next.press = '0;
    for (int i = 0; i < N; i++) begin
      if (btn.raw[i] != s_reg.stable[i]) begin
        if (s_reg.cnt[i] == LAST) begin
          s_next.cnt[i]    = '0;
          s_next.stable[i] = btn.raw[i];
          s_next.press[i]  = btn.raw[i]; // RL21
        end else begin
          s_next.cnt[i] = s_reg.cnt[i] + CW'(1);
        end
      end else begin
        // Any bounce back restarts the wait
        s_next.cnt[i] = '0; // RL21
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign btn.level = s_reg.stable;
  assign btn.press = s_reg.press;

endmodule : button_debounce

`default_nettype wire

// *** rtl/panel_effects_control.sv ***
// Front-panel effects, cue, loop, mic and streaming control state of the mixer
//
// Notes on behaviour
// (RL1) Processor select press flips between processor one and processor two.
// (RL2) Four insert buttons place selected processor at channel one, two, aux, main.
// (RL3) One processor per insert point; a new insertion evicts the other processor.
// (RL4) Channel insert taps pre or post fader by effect; echo is post-fader.
// (RL5) Effects cue is one global bit, untouched by processor selection.
// (RL6) Effect enable toggles on/off of the selected processor only.
// (RL7) Joy lamp off routes joy as transform, lamp on routes to parameter.
// (RL8) Joy press toggles mode and lamp unless effect lacks a second function.
// (RL9) Two-parameter encoder: lamp off adjusts first, on adjusts second; push toggles.
// (RL10) Without a second parameter, push does nothing and lamp stays off.
// (RL11) Tap encoder: lamp lit only while push held; rotation has one function.
// (RL12) Each loop button toggles channel loop routing, green lamp while assigned.
// (RL13) Master cue on gives main mix in phones, ignores pan; off pans channels.
// (RL14) Mic button switches mic path, green lamp lit while engaged.
// (RL15) Mic overload lamp lights while the mic signal is clipping.
// (RL16) USB lamp lit only while attached and actively communicating.
// (RL17) Each return stream picks channel pre/post, main mix or aux sum.
// (RL18) Streams are 16-bit, internal samples 24-bit; truncate or extend at boundary.
// (RL19) Eight USB channels: two stereo pairs each way.
// (RL20) Loop-routed channels also pass the processor inserted on the aux bus.
// (RL21) Every push switch is debounced so one press gives one toggle.
`include "panel_params.svh"
`timescale 1ns/1ns
`default_nettype none

module panel_effects_control #(
  parameter int                PROC1_EFFECT    = 0,
  parameter int                PROC2_EFFECT    = 1,
  parameter int                DEBOUNCE_CYCLES = `PANEL_DEBOUNCE_CYCLES
) (
  input  wire logic                              SYS_CLK_I,
  input  wire logic                              RSTN_I,
  // Panel push switches, high while pressed
  input  wire logic                              PROC_SELECT_BUTTON_I,
  input  wire logic                              INSERT_CHANNEL_ONE_BUTTON_I,
  input  wire logic                              INSERT_CHANNEL_TWO_BUTTON_I,
  input  wire logic                              INSERT_AUX_BUS_BUTTON_I,
  input  wire logic                              INSERT_MAIN_MIX_BUTTON_I,
  input  wire logic                              EFFECTS_CUE_TOGGLE_I,
  input  wire logic                              EFFECT_ENABLE_TOGGLE_I,
  input  wire logic                              LEFT_JOY_SWITCH_PUSH_I,
  input  wire logic                              RIGHT_JOY_SWITCH_PUSH_I,
  input  wire logic                              FIRST_PUSH_ENCODER_PUSH_I,
  input  wire logic                              SECOND_PUSH_ENCODER_PUSH_I,
  input  wire logic                              MIC_ON_BUTTON_I,
  input  wire logic                              MASTER_CUE_BUTTON_I,
  input  wire logic [1:0]                        EXT_LOOP_BUTTON_I,
  // Joy-switch positions and rotary encoders
  input  wire logic [1:0][`JOY_POS_WIDTH-1:0]    JOY_POS_I,
  input  wire logic [1:0]                        JOY_ACTIVE_I,
  input  wire logic [1:0]                        ENC_STEP_I,
  input  wire logic [1:0]                        ENC_DIR_I,
  // Status from the analog and USB side
  input  wire logic                              MIC_CLIP_I,
  input  wire logic                              USB_ATTACHED_I,
  input  wire logic                              USB_ACTIVE_I,
  input  wire logic [1:0][2:0]                   STREAM_SRC_SEL_I,
  input  wire logic                              SAMPLE_STROBE_I,
  input  wire logic [3:0][`INTERNAL_WIDTH-1:0]   TO_HOST_SAMPLE_I,
  input  wire logic [3:0][`STREAM_WIDTH-1:0]     FROM_HOST_SAMPLE_I,
  // Effects state and routing
  output wire logic                              PROC_SELECTED_O,
  output wire logic [1:0]                        FX_ON_O,
  output wire logic                              FX_CUE_O,
  output wire logic [3:0][1:0]                   INSERT_OWNER_O,
  output wire logic [1:0]                        CHANNEL_FX_POST_FADER_O,
  // Joy-switch and encoder routing
  output wire logic [1:0]                        JOY_LAMP_O,
  output wire logic [1:0][`JOY_POS_WIDTH-1:0]    JOY_POS_O,
  output wire logic [1:0]                        JOY_TRANSFORM_VALID_O,
  output wire logic [1:0]                        JOY_PARAM_VALID_O,
  output wire logic [1:0]                        ENC_LAMP_O,
  output wire logic [1:0][1:0]                   ENC_PARAM_STEP_O,
  output wire logic [1:0]                        ENC_DIR_O,
  output wire logic [1:0]                        ENC_TAP_O,
  // Mic, headphones, loop, lamps
  output wire logic                              MIC_PATH_EN_O,
  output wire logic                              MIC_LAMP_O,
  output wire logic                              OVERLOAD_LAMP_O,
  output wire logic                              HP_MAIN_MIX_O,
  output wire logic                              CUE_PAN_ACTIVE_O,
  output wire logic [1:0]                        EXT_LOOP_ASSIGN_O,
  output wire logic [1:0]                        EXT_LOOP_LAMP_O,
  output wire logic [1:0]                        EXT_LOOP_VIA_FX_O,
  output wire logic [1:0]                        EXT_LOOP_FX_OWNER_O,
  output wire logic                              USB_LINK_LAMP_O,
  // Streaming
  output wire logic [1:0][2:0]                   STREAM_SRC_O,
  output wire logic                              SAMPLE_VALID_O,
  output wire logic [3:0][`STREAM_WIDTH-1:0]     TO_HOST_SAMPLE_O,
  output wire logic [3:0][`INTERNAL_WIDTH-1:0]   FROM_HOST_SAMPLE_O
);

  panel_pkg::panel_state_t s_reg;
  panel_pkg::panel_state_t s_next;

  button_if #(.N(`BTN_COUNT)) btn ();

  // ----------
  // Debouncing of every push switch
  // ----------
  assign btn.raw = {EXT_LOOP_BUTTON_I, MASTER_CUE_BUTTON_I, MIC_ON_BUTTON_I,
                    SECOND_PUSH_ENCODER_PUSH_I, FIRST_PUSH_ENCODER_PUSH_I,
                    RIGHT_JOY_SWITCH_PUSH_I, LEFT_JOY_SWITCH_PUSH_I,
                    EFFECT_ENABLE_TOGGLE_I, EFFECTS_CUE_TOGGLE_I,
                    INSERT_MAIN_MIX_BUTTON_I, INSERT_AUX_BUS_BUTTON_I,
                    INSERT_CHANNEL_TWO_BUTTON_I, INSERT_CHANNEL_ONE_BUTTON_I,
                    PROC_SELECT_BUTTON_I};

  button_debounce #(
    .N      (`BTN_COUNT),
    .CYCLES (DEBOUNCE_CYCLES)
  ) u_debounce (
    .clk_i  (SYS_CLK_I),
    .rstn_i (RSTN_I),
    .btn    (btn)
  );

  // ----------
  // Effect capabilities
  // ----------
  function automatic panel_pkg::effect_t effect_of(input logic proc);
    effect_of = proc ? panel_pkg::effect_t'(PROC2_EFFECT[0]) : panel_pkg::effect_t'(PROC1_EFFECT[0]);
  endfunction : effect_of

  // Both built-in effects offer a multiplier on the left and wet/dry on the right
  function automatic logic joy_has_second(input panel_pkg::effect_t ef, input logic joy);
    case (ef)
      panel_pkg::EFFECT_ECHO:       joy_has_second = 1'b1;
      panel_pkg::EFFECT_LFO_FILTER: joy_has_second = 1'b1;
      default:                      joy_has_second = joy;
    endcase
  endfunction : joy_has_second

  function automatic logic enc_is_tap(input panel_pkg::effect_t ef, input logic enc);
    enc_is_tap = !enc && (ef == panel_pkg::EFFECT_ECHO || ef == panel_pkg::EFFECT_LFO_FILTER);
  endfunction : enc_is_tap

  function automatic logic enc_has_two(input panel_pkg::effect_t ef, input logic enc);
    enc_has_two = enc && (ef == panel_pkg::EFFECT_LFO_FILTER);
  endfunction : enc_has_two

  function automatic logic taps_post_fader(input panel_pkg::effect_t ef);
    taps_post_fader = (ef == panel_pkg::EFFECT_ECHO); // RL4
  endfunction : taps_post_fader

  function automatic panel_pkg::insert_loc_t point_loc(input int k);
    case (k)
      0:       point_loc = panel_pkg::LOC_PGM1;
      1:       point_loc = panel_pkg::LOC_PGM2;
      2:       point_loc = panel_pkg::LOC_AUX;
      default: point_loc = panel_pkg::LOC_MAIN;
    endcase
  endfunction : point_loc

  function automatic panel_pkg::owner_t owner_at(input panel_pkg::insert_loc_t [1:0] loc,
                                                  input panel_pkg::insert_loc_t p);
    if (loc[0] == p) begin
      owner_at = panel_pkg::OWNER_PROC1;
    end else if (loc[1] == p) begin
      owner_at = panel_pkg::OWNER_PROC2;
    end else begin
      owner_at = panel_pkg::OWNER_NONE;
    end
  endfunction : owner_at

  // ----------
  // Next state
  // ----------
  always_comb begin
    logic                  cur;
    logic                  second;
    panel_pkg::effect_t    ef;
    panel_pkg::insert_loc_t tgt;
    cur    = s_reg.sel;
    second = 1'b0;
    ef     = effect_of(s_reg.sel);
    tgt    = panel_pkg::LOC_NONE;
    s_next = s_reg;

    if (btn.press[`BTN_PROC_SELECT]) begin
      s_next.sel = ~s_reg.sel; // RL1
    end

    // Later buttons win when several land in one cycle
    for (int k = 0; k < `BTN_INSERT_COUNT; k++) begin
      if (btn.press[`BTN_INSERT_FIRST + k]) begin
        tgt             = point_loc(k);
        s_next.loc[cur] = tgt; // RL2
        if (s_reg.loc[~cur] == tgt) begin
          s_next.loc[~cur] = panel_pkg::LOC_NONE; // RL3
        end
      end
    end

    if (btn.press[`BTN_FX_CUE]) begin
      s_next.fx_cue = ~s_reg.fx_cue; // RL5
    end
    if (btn.press[`BTN_FX_ENABLE]) begin
      s_next.fx_on[cur] = ~s_reg.fx_on[cur]; // RL6
    end

    for (int j = 0; j < 2; j++) begin
      if (btn.press[`BTN_JOY_FIRST + j] && joy_has_second(ef, j[0])) begin
        s_next.joy_mode[cur][j] = ~s_reg.joy_mode[cur][j]; // RL8
      end
      s_next.joy_lamp[j]            = s_next.joy_mode[s_next.sel][j]; // RL8
      s_next.joy_pos[j]             = JOY_POS_I[j];
      s_next.joy_transform_valid[j] = JOY_ACTIVE_I[j] & ~s_reg.joy_mode[cur][j]; // RL7
      s_next.joy_param_valid[j]     = JOY_ACTIVE_I[j] & s_reg.joy_mode[cur][j]; // RL7
    end

    for (int e = 0; e < 2; e++) begin
      s_next.tap[e] = 1'b0;
      second        = 1'b0;
      if (enc_is_tap(ef, e[0])) begin
        s_next.enc_lamp[e] = btn.level[`BTN_ENC_FIRST + e]; // RL11
        s_next.tap[e]      = btn.press[`BTN_ENC_FIRST + e]; // RL11
      end else if (enc_has_two(ef, e[0])) begin
        if (btn.press[`BTN_ENC_FIRST + e]) begin
          s_next.enc_mode[cur][e] = ~s_reg.enc_mode[cur][e]; // RL9
        end
        second             = s_reg.enc_mode[cur][e];
        s_next.enc_lamp[e] = s_next.enc_mode[cur][e]; // RL9
      end else begin
        s_next.enc_lamp[e] = 1'b0; // RL10
      end
      s_next.enc_step[e] = {ENC_STEP_I[e] & second, ENC_STEP_I[e] & ~second}; // RL9
      s_next.enc_dir[e]  = ENC_DIR_I[e];
    end

    // Owners follow the newly computed locations
    for (int p = 0; p < 4; p++) begin
      s_next.point_owner[p] = owner_at(s_next.loc, point_loc(p));
    end
    for (int c = 0; c < 2; c++) begin
      s_next.post_fader[c] = 1'b0;
      if (s_next.point_owner[c] == panel_pkg::OWNER_PROC1) begin
        s_next.post_fader[c] = taps_post_fader(effect_of(1'b0)); // RL4
      end else if (s_next.point_owner[c] == panel_pkg::OWNER_PROC2) begin
        s_next.post_fader[c] = taps_post_fader(effect_of(1'b1)); // RL4
      end
    end

    if (btn.press[`BTN_MIC]) begin
      s_next.mic_on = ~s_reg.mic_on; // RL14
    end
    s_next.mic_clip = MIC_CLIP_I; // RL15
    s_next.usb_link = USB_ATTACHED_I & USB_ACTIVE_I; // RL16

    if (btn.press[`BTN_MASTER_CUE]) begin
      s_next.master_cue = ~s_reg.master_cue; // RL13
    end
    s_next.cue_pan_active = ~s_next.master_cue; // RL13

    s_next.loop_fx_owner = s_next.point_owner[2];
    for (int c = 0; c < 2; c++) begin
      if (btn.press[`BTN_LOOP_FIRST + c]) begin
        s_next.loop_assign[c] = ~s_reg.loop_assign[c]; // RL12
      end
      s_next.loop_via_fx[c] = s_next.loop_assign[c] &&
                              (s_next.loop_fx_owner != panel_pkg::OWNER_NONE); // RL20
    end

    // Undefined source codes are ignored so the stream keeps its last source
    for (int k = 0; k < `STREAM_COUNT; k++) begin
      if (STREAM_SRC_SEL_I[k] < `SRC_CODE_COUNT) begin
        s_next.src[k] = panel_pkg::stream_src_t'(STREAM_SRC_SEL_I[k]); // RL17
      end
    end

    // Truncation drops the low byte; no dither is applied
    s_next.sample_valid = SAMPLE_STROBE_I;
    if (SAMPLE_STROBE_I) begin
      for (int ch = 0; ch < `STREAM_CHANNELS; ch++) begin
        s_next.to_host[ch]   = TO_HOST_SAMPLE_I[ch][`INTERNAL_WIDTH-1 -: `STREAM_WIDTH]; // RL18 RL19
        s_next.from_host[ch] = {FROM_HOST_SAMPLE_I[ch],
                                {(`INTERNAL_WIDTH - `STREAM_WIDTH){1'b0}}}; // RL18 RL19
      end
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      s_reg                <= '0;
      s_reg.cue_pan_active <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------
  // Outputs, each a state flop
  // ----------
  assign PROC_SELECTED_O         = s_reg.sel;
  assign FX_ON_O                 = s_reg.fx_on;
  assign FX_CUE_O                = s_reg.fx_cue;
  assign INSERT_OWNER_O          = s_reg.point_owner;
  assign CHANNEL_FX_POST_FADER_O = s_reg.post_fader;
  assign JOY_LAMP_O              = s_reg.joy_lamp;
  assign JOY_POS_O               = s_reg.joy_pos;
  assign JOY_TRANSFORM_VALID_O   = s_reg.joy_transform_valid;
  assign JOY_PARAM_VALID_O       = s_reg.joy_param_valid;
  assign ENC_LAMP_O              = s_reg.enc_lamp;
  assign ENC_PARAM_STEP_O        = s_reg.enc_step;
  assign ENC_DIR_O               = s_reg.enc_dir;
  assign ENC_TAP_O               = s_reg.tap;
  assign MIC_PATH_EN_O           = s_reg.mic_on;
  assign MIC_LAMP_O              = s_reg.mic_on;
  assign OVERLOAD_LAMP_O         = s_reg.mic_clip;
  assign HP_MAIN_MIX_O           = s_reg.master_cue;
  assign CUE_PAN_ACTIVE_O        = s_reg.cue_pan_active;
  assign EXT_LOOP_ASSIGN_O       = s_reg.loop_assign;
  assign EXT_LOOP_LAMP_O         = s_reg.loop_assign;
  assign EXT_LOOP_VIA_FX_O       = s_reg.loop_via_fx;
  assign EXT_LOOP_FX_OWNER_O     = s_reg.loop_fx_owner;
  assign USB_LINK_LAMP_O         = s_reg.usb_link;
  assign STREAM_SRC_O            = s_reg.src;
  assign SAMPLE_VALID_O          = s_reg.sample_valid;
  assign TO_HOST_SAMPLE_O        = s_reg.to_host;
  assign FROM_HOST_SAMPLE_O      = s_reg.from_host;

endmodule : panel_effects_control

`default_nettype wire

// *** sim/panel_asserts.sv ***
// Port-level checker for the panel effects control block
`timescale 1ns/1ns
`default_nettype none
module panel_asserts (
  input wire logic             SYS_CLK_I,
  input wire logic             RSTN_I,
  input wire logic             MIC_CLIP_I,
  input wire logic             USB_ATTACHED_I,
  input wire logic             USB_ACTIVE_I,
  input wire logic             SAMPLE_STROBE_I,
  input wire logic [3:0][23:0] TO_HOST_SAMPLE_I,
  input wire logic             OVERLOAD_LAMP_O,
  input wire logic             USB_LINK_LAMP_O,
  input wire logic             MIC_LAMP_O,
  input wire logic             MIC_PATH_EN_O,
  input wire logic             CUE_PAN_ACTIVE_O,
  input wire logic             HP_MAIN_MIX_O,
  input wire logic [1:0]       EXT_LOOP_LAMP_O,
  input wire logic [1:0]       EXT_LOOP_ASSIGN_O,
  input wire logic             PROC_SELECTED_O,
  input wire logic             FX_CUE_O,
  input wire logic [1:0]       FX_ON_O,
  input wire logic             SAMPLE_VALID_O,
  input wire logic [3:0][15:0] TO_HOST_SAMPLE_O,
  input wire logic [1:0]       JOY_TRANSFORM_VALID_O,
  input wire logic [1:0]       JOY_PARAM_VALID_O
);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RSTN_I);
  AST_OVERLOAD_CLIP: assert property (OVERLOAD_LAMP_O == $past(MIC_CLIP_I))
    else $error("overload lamp not following clip");
  AST_USB_LAMP: assert property (USB_LINK_LAMP_O == $past(USB_ATTACHED_I && USB_ACTIVE_I))
    else $error("usb lamp wrong");
  AST_MIC_LAMP: assert property (MIC_LAMP_O == MIC_PATH_EN_O)
    else $error("mic lamp differs from mic path");
  AST_CUE_PAN: assert property (CUE_PAN_ACTIVE_O != HP_MAIN_MIX_O)
    else $error("cue pan not inverse of master cue");
  AST_LOOP_LAMP: assert property (EXT_LOOP_LAMP_O == EXT_LOOP_ASSIGN_O)
    else $error("loop lamp differs from assignment");
  AST_CUE_GLOBAL: assert property ($changed(PROC_SELECTED_O) |-> $stable(FX_CUE_O))
    else $error("effects cue changed with selection");
  AST_FX_ON_SEL: assert property ($changed(FX_ON_O) |->
    (FX_ON_O ^ $past(FX_ON_O)) == (2'h1 << $past(PROC_SELECTED_O)))
    else $error("unselected processor toggled");
  AST_SAMPLE_TRUNC: assert property (SAMPLE_STROBE_I |=>
    TO_HOST_SAMPLE_O[3] == $past(TO_HOST_SAMPLE_I[3][23:8]))
    else $error("stream word not truncated");
  AST_SAMPLE_VALID: assert property (SAMPLE_VALID_O == $past(SAMPLE_STROBE_I))
    else $error("sample valid timing wrong");
  AST_JOY_SPLIT: assert property ((JOY_TRANSFORM_VALID_O & JOY_PARAM_VALID_O) == 2'h0)
    else $error("joy routed to both functions");
endmodule : panel_asserts
`default_nettype wire

// *** sim/panel_model.sv ***
// Front-panel push switch model driving raw switch levels
`timescale 1ns/1ns
`default_nettype none
module panel_model (
  input  wire logic        clk_i,
  output var  logic [14:0] btn_o
);
  initial btn_o = 15'h0000;
  // Release is held long enough to be debounced before the next press
  task automatic press(input int idx, input int len);
    @(negedge clk_i) btn_o[idx] = 1'b1;
    repeat (len) @(negedge clk_i);
    btn_o[idx] = 1'b0;
    repeat (7) @(negedge clk_i);
  endtask : press
endmodule : panel_model
`default_nettype wire

// *** sim/panel_effects_control_test.sv ***
// Self-checking bench for the panel effects control block
`timescale 1ns/1ns
`default_nettype none
module panel_effects_control_test;
  logic             clk, rstn, strobe, clip, att, act;
  logic [1:0]       jact, step, dir;
  logic [1:0][2:0]  jpos, ssel;
  logic [3:0][23:0] th;
  logic [3:0][15:0] fh;
  wire logic [14:0] b;
  int               fails = 0, n_compared = 0;
  panel_model m (.clk_i(clk), .btn_o(b));
  panel_effects_control #(.DEBOUNCE_CYCLES(4)) dut_u (.SYS_CLK_I(clk), .RSTN_I(rstn),
    .PROC_SELECT_BUTTON_I(b[0]), .INSERT_CHANNEL_ONE_BUTTON_I(b[1]), .INSERT_CHANNEL_TWO_BUTTON_I(b[2]),
    .INSERT_AUX_BUS_BUTTON_I(b[3]), .INSERT_MAIN_MIX_BUTTON_I(b[4]), .EFFECTS_CUE_TOGGLE_I(b[5]),
    .EFFECT_ENABLE_TOGGLE_I(b[6]), .LEFT_JOY_SWITCH_PUSH_I(b[7]), .RIGHT_JOY_SWITCH_PUSH_I(b[8]),
    .FIRST_PUSH_ENCODER_PUSH_I(b[9]), .SECOND_PUSH_ENCODER_PUSH_I(b[10]), .MIC_ON_BUTTON_I(b[11]),
    .MASTER_CUE_BUTTON_I(b[12]), .EXT_LOOP_BUTTON_I(b[14:13]), .JOY_POS_I(jpos), .JOY_ACTIVE_I(jact),
    .ENC_STEP_I(step), .ENC_DIR_I(dir), .MIC_CLIP_I(clip), .USB_ATTACHED_I(att), .USB_ACTIVE_I(act),
    .STREAM_SRC_SEL_I(ssel), .SAMPLE_STROBE_I(strobe), .TO_HOST_SAMPLE_I(th), .FROM_HOST_SAMPLE_I(fh),
    .PROC_SELECTED_O(), .FX_ON_O(), .FX_CUE_O(), .INSERT_OWNER_O(), .CHANNEL_FX_POST_FADER_O(),
    .JOY_LAMP_O(), .JOY_POS_O(), .JOY_TRANSFORM_VALID_O(), .JOY_PARAM_VALID_O(), .ENC_LAMP_O(),
    .ENC_PARAM_STEP_O(), .ENC_DIR_O(), .ENC_TAP_O(), .MIC_PATH_EN_O(), .MIC_LAMP_O(), .OVERLOAD_LAMP_O(),
    .HP_MAIN_MIX_O(), .CUE_PAN_ACTIVE_O(), .EXT_LOOP_ASSIGN_O(), .EXT_LOOP_LAMP_O(), .EXT_LOOP_VIA_FX_O(),
    .EXT_LOOP_FX_OWNER_O(), .USB_LINK_LAMP_O(), .STREAM_SRC_O(), .SAMPLE_VALID_O(), .TO_HOST_SAMPLE_O(),
    .FROM_HOST_SAMPLE_O());
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  task automatic t_effects();
    m.press(6, 6);
    chk("fx_on", 1, dut_u.FX_ON_O);
    m.press(5, 6);
    m.press(0, 6);
    chk("sel", 1, dut_u.PROC_SELECTED_O);
    chk("fx_cue", 1, dut_u.FX_CUE_O);
    m.press(6, 6);
    chk("fx_on", 3, dut_u.FX_ON_O);
    m.press(0, 6);
    chk("sel", 0, dut_u.PROC_SELECTED_O);
  endtask : t_effects
  task automatic t_insert();
    m.press(1, 6);
    chk("owner", 8'h01, dut_u.INSERT_OWNER_O);
    chk("post", 1, dut_u.CHANNEL_FX_POST_FADER_O);
    m.press(0, 6);
    m.press(1, 6);
    chk("owner", 8'h02, dut_u.INSERT_OWNER_O);
    chk("post", 0, dut_u.CHANNEL_FX_POST_FADER_O);
    m.press(3, 6);
    m.press(13, 6);
    chk("owner", 8'h20, dut_u.INSERT_OWNER_O);
    chk("loop", 1, dut_u.EXT_LOOP_ASSIGN_O);
    chk("via", 1, dut_u.EXT_LOOP_VIA_FX_O);
    chk("loop_own", 2, dut_u.EXT_LOOP_FX_OWNER_O);
    m.press(0, 6);
    m.press(4, 6);
    chk("owner", 8'h60, dut_u.INSERT_OWNER_O);
    m.press(2, 6);
    m.press(13, 6);
    chk("owner", 8'h24, dut_u.INSERT_OWNER_O);
    chk("loop", 0, dut_u.EXT_LOOP_ASSIGN_O);
  endtask : t_insert
  task automatic t_panel();
    m.press(11, 2);
    chk("mic", 0, dut_u.MIC_PATH_EN_O);
    m.press(11, 6);
    chk("mic", 1, dut_u.MIC_LAMP_O);
    m.press(12, 6);
    chk("hp_main", 1, dut_u.HP_MAIN_MIX_O);
    clip = 1'b1;
    att  = 1'b1;
    act  = 1'b1;
    @(negedge clk) chk("ovl", 1, dut_u.OVERLOAD_LAMP_O);
    chk("usb", 1, dut_u.USB_LINK_LAMP_O);
    act = 1'b0;
    @(negedge clk) chk("usb", 0, dut_u.USB_LINK_LAMP_O);
    m.press(10, 6);
    chk("enc_lamp", 0, dut_u.ENC_LAMP_O);
    m.press(0, 6);
    m.press(10, 6);
    chk("enc_lamp", 2, dut_u.ENC_LAMP_O);
    step = 2'h2;
    dir  = 2'h2;
    @(negedge clk) chk("enc_step", 8'h08, dut_u.ENC_PARAM_STEP_O);
    chk("enc_dir", 2, dut_u.ENC_DIR_O);
    step = 2'h0;
    m.press(7, 6);
    chk("joy_lamp", 1, dut_u.JOY_LAMP_O);
    jact = 2'h3;
    jpos = 6'h2A;
    @(negedge clk) chk("joy_par", 1, dut_u.JOY_PARAM_VALID_O);
    chk("joy_trn", 2, dut_u.JOY_TRANSFORM_VALID_O);
    chk("joy_pos", 6'h2A, dut_u.JOY_POS_O);
    // Tap pulse and lamp show one edge after the debounced press
    fork
      m.press(9, 6);
      begin
        repeat (6) @(negedge clk);
        chk("tap", 1, dut_u.ENC_TAP_O);
        chk("tap_lamp", 1, dut_u.ENC_LAMP_O[0]);
      end
    join
    chk("tap_lamp", 0, dut_u.ENC_LAMP_O[0]);
  endtask : t_panel
  task automatic t_stream();
    for (int c = 0; c < 7; c++) begin
      ssel = {c[2:0], c[2:0]};
      @(negedge clk) chk("src", (c < 6) ? {c[2:0], c[2:0]} : 6'h2D, dut_u.STREAM_SRC_O);
    end
    for (int i = 0; i < 4; i++) begin
      th[i] = 24'h123456 + 24'(i);
      fh[i] = 16'hABC0 + 16'(i);
    end
    strobe = 1'b1;
    @(negedge clk) strobe = 1'b0;
    chk("valid", 1, dut_u.SAMPLE_VALID_O);
    for (int i = 0; i < 4; i++) begin
      chk("to_host", th[i][23:8], dut_u.TO_HOST_SAMPLE_O[i]);
      chk("from_host", {fh[i], 8'h00}, dut_u.FROM_HOST_SAMPLE_O[i]);
    end
  endtask : t_stream
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    {rstn, strobe, clip, att, act, jact, step, dir, jpos, ssel, th, fh} = '0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    chk("cue_pan", 1, dut_u.CUE_PAN_ACTIVE_O);
    t_effects();
    t_insert();
    t_panel();
    t_stream();
    test_done();
  end
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    test_done();
  end
endmodule : panel_effects_control_test
bind panel_effects_control panel_asserts chk_u (.*);
`default_nettype wire
